/* File: core/acc_filter_match.sv */
// One acceptance filter compared against one received identifier
`timescale 1ns/1ns
module acc_filter_match (
   // Filter and selected mask words
   input  wire logic [15:0] filt_std,
   input  wire logic [15:0] filt_ext,
   input  wire logic [15:0] mask_std,
   input  wire logic [15:0] mask_ext,
   input  wire logic        mask_valid,
   // Received identifier
   input  wire logic        msg_ide,
   input  wire logic [10:0] msg_sid,
   input  wire logic [17:0] msg_eid,
   // Result
   output logic             match
);
   import can_rx_pkg::*;

   logic sid_ok;
   logic eid_ok;
   logic id_ok;
   logic type_ok;

   // Only bits the mask includes must equal the filter bits
   assign sid_ok = ((filt_std[15:SID_LSB] ^ msg_sid) & mask_std[15:SID_LSB]) == '0;
   assign eid_ok = (({filt_std[1:0], filt_ext} ^ msg_eid)
                    & {mask_std[1:0], mask_ext}) == '0;
   // Standard frames carry no extended bits to compare
   assign id_ok = msg_ide ? (sid_ok & eid_ok) : sid_ok;
   // Format check only when the mask asks for it
   assign type_ok = !mask_std[TYPE_BIT] || (filt_std[TYPE_BIT] == msg_ide);
   assign match = mask_valid & type_ok & id_ok;
endmodule // acc_filter_match

/* File: core/can_rx_accept.sv */
// Acceptance masks for filters 8-15 and receive buffer full/overflow flags
//
// Local design decisions: the register addresses and the Wishbone register port.
`timescale 1ns/1ns
module can_rx_accept (
   // Clock and reset
   input  wire logic        CLOCK,
   input  wire logic        RESET,
   // Wishbone slave
   input  wire logic        CYC_I,
   input  wire logic        STB_I,
   input  wire logic        WE_I,
   input  wire logic [7:0]  ADR_I,
   input  wire logic [3:0]  SEL_I,
   input  wire logic [31:0] DAT_I,
   output logic [31:0]      DAT_O,
   output logic             ACK_O,
   // Received identifier from the protocol engine
   input  wire logic        MSG_VALID,
   input  wire logic        MSG_IDE,
   input  wire logic [10:0] MSG_SID,
   input  wire logic [17:0] MSG_EID,
   // Acceptance result
   output logic             HIT_VALID,
   output logic [3:0]       HIT_FILTER,
   // Buffer store event from the buffer writer
   input  wire logic        STORE_VALID,
   input  wire logic [4:0]  STORE_BUF,
   // Interrupt
   output logic             IRQ
);
   import can_rx_pkg::*;

   // ==================================================================
   // Declarations
   logic [15:0]           fmsel_q;
   logic [15:0]           mstd_q [NUM_MASK];
   logic [15:0]           mext_q [NUM_MASK];
   logic [15:0]           fstd_q [NUM_FILT];
   logic [15:0]           fext_q [NUM_FILT];
   logic [7:0]            fen_q;
   logic [NUM_FILT-1:0]   match;
   logic [NUM_BUF-1:0]    full_q;
   logic [NUM_BUF-1:0]    ovf_q;
   logic [NUM_BUF-1:0]    full_set;
   logic [NUM_BUF-1:0]    ovf_set;
   logic [NUM_BUF-1:0]    full_clr;
   logic [NUM_BUF-1:0]    ovf_clr;
   logic [IRQ_W-1:0]      irq_stat_q;
   logic [IRQ_W-1:0]      irq_stat_d;
   logic [IRQ_W-1:0]      irq_en_q;
   logic [IRQ_W-1:0]      irq_clr;
   logic [IRQ_W-1:0]      irq_set;
   logic                  hit_any;
   logic [2:0]            hit_idx;
   logic [4:0]            last_hit_q;
   logic [5:0]            wadr;
   logic [15:0]           lmask;
   logic                  req;
   logic                  wr_en;
   logic [31:0]           rd_d;

   // ==================================================================
   // Helper functions
   // Byte enables of the low two lanes widened to a bit mask
   function automatic logic [15:0] lane_mask(input logic [3:0] sel);
      lane_mask = {{8{sel[1]}}, {8{sel[0]}}};
   endfunction

   // Zero-written bits of one half of a flag pair become clear bits
   function automatic logic [31:0] clr_pair(input logic en, input logic [5:0] adr,
                                            input logic [5:0] lo_w, input logic [15:0] dat,
                                            input logic [15:0] lm);
      logic [15:0] c;
      c = ~dat & lm;
      clr_pair = '0;
      if (en && adr == lo_w) begin
         clr_pair = {16'h0000, c};
      end else if (en && adr == lo_w + 6'h01) begin
         clr_pair = {c, 16'h0000};
      end
   endfunction

   // Filter word decode, used by writes and reads; words above the last filter stay unmapped
   function automatic logic is_filt(input logic [5:0] adr);
      is_filt = adr >= W_FILT0 && adr < W_FILT0 + 6'(2*NUM_FILT);
   endfunction

   // ==================================================================
   // Bus handshake
   assign req = CYC_I & STB_I;
   assign wadr = ADR_I[7:2];
   assign lmask = lane_mask(SEL_I);
   // Write lands on the edge that the master samples ack
   assign wr_en = req & WE_I & ACK_O;

   // Ack one cycle after the request, dropped the cycle after
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         ACK_O <= 1'b0;
      end else begin
         ACK_O <= req & ~ACK_O;
      end
   end

   // Read data captured with the ack so it comes from a flop
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         DAT_O <= 32'h0000_0000;
      end else if (req && !ACK_O) begin
         DAT_O <= WE_I ? 32'h0000_0000 : rd_d;
      end
   end

   // ==================================================================
   // Mask select and filter enable registers
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         fmsel_q <= RST_FMSEL;
         fen_q <= RST_FEN;
      end else if (wr_en) begin
         if (wadr == W_FMSEL) begin
            fmsel_q <= (fmsel_q & ~lmask) | (DAT_I[15:0] & lmask);
         end
         if (wadr == W_FEN && SEL_I[0]) begin
            fen_q <= DAT_I[7:0];
         end
      end
   end

   // ==================================================================
   // Acceptance masks and filter words
   genvar gm;
   generate
      for (gm = 0; gm < NUM_MASK; gm++) begin : g_mask
         // Unused bits are never stored so they cannot read back
         always_ff @(posedge CLOCK or posedge RESET) begin
            if (RESET) begin
               mstd_q[gm] <= RST_ID;
               mext_q[gm] <= RST_ID;
            end else if (wr_en) begin
               if (wadr == W_MSTD0 + 6'(gm)) begin
                  mstd_q[gm] <= (mstd_q[gm] & ~lmask) | (DAT_I[15:0] & lmask & ~STD_RSVD);
               end
               if (wadr == W_MEXT0 + 6'(gm)) begin
                  mext_q[gm] <= (mext_q[gm] & ~lmask) | (DAT_I[15:0] & lmask);
               end
            end
         end
      end

      for (gm = 0; gm < NUM_FILT; gm++) begin : g_filt
         logic [1:0] code;
         logic [1:0] idx;
         // Two bits per filter, filter 8 lowest
         assign code = fmsel_q[2*gm +: 2];
         // Reserved code matches nothing, index kept in range
         assign idx = (code == MSEL_RSVD) ? MSEL_M0 : code;

         always_ff @(posedge CLOCK or posedge RESET) begin
            if (RESET) begin
               fstd_q[gm] <= RST_ID;
               fext_q[gm] <= RST_ID;
            end else if (wr_en && is_filt(wadr)) begin
               if (wadr == W_FILT0 + 6'(2*gm)) begin
                  fstd_q[gm] <= (fstd_q[gm] & ~lmask) | (DAT_I[15:0] & lmask & ~STD_RSVD);
               end
               if (wadr == W_FILT0 + 6'(2*gm + 1)) begin
                  fext_q[gm] <= (fext_q[gm] & ~lmask) | (DAT_I[15:0] & lmask);
               end
            end
         end

         acc_filter_match u_match (
            .filt_std   (fstd_q[gm]),
            .filt_ext   (fext_q[gm]),
            .mask_std   (mstd_q[idx]),
            .mask_ext   (mext_q[idx]),
            .mask_valid (fen_q[gm] && code != MSEL_RSVD),
            .msg_ide    (MSG_IDE),
            .msg_sid    (MSG_SID),
            .msg_eid    (MSG_EID),
            .match      (match[gm])
         );
      end
   endgenerate

   // ==================================================================
   // Hit priority, lowest filter number wins
   always_comb begin
      hit_any = |match;
      hit_idx = 3'h0;
      for (int i = NUM_FILT - 1; i >= 0; i--) begin
         if (match[i]) begin
            hit_idx = 3'(i);
         end
      end
   end

   // Hit reported one cycle after the identifier
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         HIT_VALID <= 1'b0;
         HIT_FILTER <= 4'h0;
         last_hit_q <= 5'h00;
      end else begin
         HIT_VALID <= MSG_VALID & hit_any;
         if (MSG_VALID && hit_any) begin
            HIT_FILTER <= 4'(FILT_BASE) + {1'b0, hit_idx};
            last_hit_q <= {1'b1, 4'(FILT_BASE) + {1'b0, hit_idx}};
         end
      end
   end

   // ==================================================================
   // Buffer full and overflow flags
   // Overflow looks at the full flag before this store lands
   assign full_set = STORE_VALID ? (32'h0000_0001 << STORE_BUF) : '0;
   assign ovf_set = full_set & full_q;
   // Only zeros written clear, ones are ignored
   assign full_clr = clr_pair(wr_en, wadr, W_FULL_LO, DAT_I[15:0], lmask);
   assign ovf_clr = clr_pair(wr_en, wadr, W_OVF_LO, DAT_I[15:0], lmask);

   rx_flag_bank #(.N(NUM_BUF)) u_full (
      .clk     (CLOCK),
      .rst     (RESET),
      .set_vec (full_set),
      .clr_vec (full_clr),
      .flags_q (full_q)
   );

   rx_flag_bank #(.N(NUM_BUF)) u_ovf (
      .clk     (CLOCK),
      .rst     (RESET),
      .set_vec (ovf_set),
      .clr_vec (ovf_clr),
      .flags_q (ovf_q)
   );

   // ==================================================================
   // Interrupt status, clear and enable
   assign irq_set = {|ovf_set, MSG_VALID & hit_any};
   assign irq_clr = (wr_en && wadr == W_IRQ_CLR && SEL_I[0]) ? DAT_I[IRQ_W-1:0] : '0;
   assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;

   // Status is sticky; an event in the clear cycle survives
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         irq_stat_q <= RST_IRQ;
      end else begin
         irq_stat_q <= irq_stat_d;
      end
   end

   // Enable register
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         irq_en_q <= RST_IRQ;
      end else if (wr_en && wadr == W_IRQ_EN && SEL_I[0]) begin
         irq_en_q <= DAT_I[IRQ_W-1:0];
      end
   end

   // Level output tracks the status that the next edge will hold
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(irq_stat_d & irq_en_q);
      end
   end

   // ==================================================================
   // Read multiplexer, unmapped words read zero
   always_comb begin
      rd_d = 32'h0000_0000;
      if (is_filt(wadr)) begin
         rd_d[15:0] = wadr[0] ? fext_q[wadr[3:1]] : fstd_q[wadr[3:1]];
      end else begin
         unique case (wadr)
            W_FMSEL:           rd_d[15:0] = fmsel_q;
            W_MSTD0:           rd_d[15:0] = mstd_q[0];
            W_MSTD0 + 6'h01:   rd_d[15:0] = mstd_q[1];
            W_MSTD0 + 6'h02:   rd_d[15:0] = mstd_q[2];
            W_MEXT0:           rd_d[15:0] = mext_q[0];
            W_MEXT0 + 6'h01:   rd_d[15:0] = mext_q[1];
            W_MEXT0 + 6'h02:   rd_d[15:0] = mext_q[2];
            W_FEN:             rd_d[7:0] = fen_q;
            W_FULL_LO:         rd_d[15:0] = full_q[15:0];
            W_FULL_HI:         rd_d[15:0] = full_q[31:16];
            W_OVF_LO:          rd_d[15:0] = ovf_q[15:0];
            W_OVF_HI:          rd_d[15:0] = ovf_q[31:16];
            W_IRQ_STAT:        rd_d[IRQ_W-1:0] = irq_stat_q;
            W_IRQ_EN:          rd_d[IRQ_W-1:0] = irq_en_q;
            W_HIT:             rd_d[4:0] = last_hit_q;
            default:           rd_d = 32'h0000_0000;
         endcase
      end
   end

   // ==================================================================
   // Checks
   a_full_on_store: assert property (
      @(posedge CLOCK) disable iff (RESET)
      STORE_VALID |=> full_q[$past(STORE_BUF)])
      else $error("store did not set full flag");

   a_ovf_on_full: assert property (
      @(posedge CLOCK) disable iff (RESET)
      STORE_VALID && full_q[STORE_BUF] |=> ovf_q[$past(STORE_BUF)])
      else $error("store to full buffer did not set overflow");

   a_ovf_has_cause: assert property (
      @(posedge CLOCK) disable iff (RESET)
      (ovf_q & ~$past(ovf_q)) != '0 |-> $past(STORE_VALID) && $past(full_q) != '0)
      else $error("overflow rose without a store to a full buffer");

   a_full_clr_cause: assert property (
      @(posedge CLOCK) disable iff (RESET)
      (~full_q & $past(full_q)) != '0 |->
         $past(wr_en) && ($past(wadr) == W_FULL_LO || $past(wadr) == W_FULL_HI))
      else $error("full flag fell without a software write");

   a_ovf_clr_cause: assert property (
      @(posedge CLOCK) disable iff (RESET)
      (~ovf_q & $past(ovf_q)) != '0 |->
         $past(wr_en) && ($past(wadr) == W_OVF_LO || $past(wadr) == W_OVF_HI))
      else $error("overflow flag fell without a software write");

   a_ones_no_effect: assert property (
      @(posedge CLOCK) disable iff (RESET)
      wr_en && wadr == W_FULL_LO && DAT_I[15:0] == 16'hffff
         |=> full_q[15:0] == ($past(full_q[15:0]) | $past(full_set[15:0])))
      else $error("writing ones changed full flags");

   a_rsvd_read_zero: assert property (
      @(posedge CLOCK) disable iff (RESET)
      req && !WE_I && !ACK_O && wadr >= W_MSTD0 && wadr < W_MEXT0
         ##1 ACK_O |-> DAT_O[4] == 1'b0 && DAT_O[2] == 1'b0)
      else $error("unused mask bits read as one");

   a_rsvd_no_hit: assert property (
      @(posedge CLOCK) disable iff (RESET)
      MSG_VALID && fmsel_q[15:14] == MSEL_RSVD |=> !(HIT_VALID && HIT_FILTER == 4'hf))
      else $error("filter with reserved mask code hit");

   a_type_select: assert property (
      @(posedge CLOCK) disable iff (RESET)
      MSG_VALID && fmsel_q[1:0] == MSEL_M1 && mstd_q[1][TYPE_BIT]
         && fstd_q[0][TYPE_BIT] != MSG_IDE |=> !(HIT_VALID && HIT_FILTER == 4'h8))
      else $error("frame of wrong format accepted");

   a_hit_timing: assert property (
      @(posedge CLOCK) disable iff (RESET)
      MSG_VALID && match != '0 |=> HIT_VALID ##1 !HIT_VALID || $past(MSG_VALID))
      else $error("hit not reported one cycle after identifier");

   a_ack_pulse: assert property (
      @(posedge CLOCK) disable iff (RESET)
      req && !ACK_O |=> ACK_O ##1 !ACK_O)
      else $error("ack not a single cycle");
endmodule // can_rx_accept

/* File: core/can_rx_pkg.sv */
// Constants shared by the receive acceptance and buffer flag block
package can_rx_pkg;

   // ==================================================================
   // Sizes
   localparam int NUM_FILT = 8;
   localparam int FILT_BASE = 8;
   localparam int NUM_MASK = 3;
   localparam int NUM_BUF = 32;

   // ==================================================================
   // Word indices, byte address = index * 4
   localparam logic [5:0] W_FMSEL    = 6'h00;
   localparam logic [5:0] W_MSTD0    = 6'h01;
   localparam logic [5:0] W_MEXT0    = 6'h04;
   localparam logic [5:0] W_FEN      = 6'h07;
   localparam logic [5:0] W_FULL_LO  = 6'h08;
   localparam logic [5:0] W_FULL_HI  = 6'h09;
   localparam logic [5:0] W_OVF_LO   = 6'h0a;
   localparam logic [5:0] W_OVF_HI   = 6'h0b;
   localparam logic [5:0] W_IRQ_STAT = 6'h0c;
   localparam logic [5:0] W_IRQ_CLR  = 6'h0d;
   localparam logic [5:0] W_IRQ_EN   = 6'h0e;
   localparam logic [5:0] W_HIT      = 6'h0f;
   localparam logic [5:0] W_FILT0    = 6'h10;

   // ==================================================================
   // Field layout of identifier and mask words
   localparam int SID_LSB = 5;
   localparam int TYPE_BIT = 3;
   localparam logic [15:0] STD_RSVD = 16'h0014;
   localparam logic [1:0] MSEL_M0 = 2'h0;
   localparam logic [1:0] MSEL_M1 = 2'h1;
   localparam logic [1:0] MSEL_M2 = 2'h2;
   localparam logic [1:0] MSEL_RSVD = 2'h3;
   localparam int IRQ_ACCEPT = 0;
   localparam int IRQ_OVF = 1;
   localparam int IRQ_W = 2;

   // ==================================================================
   // Reset values
   localparam logic [15:0] RST_FMSEL = 16'h0000;
   localparam logic [15:0] RST_ID = 16'h0000;
   localparam logic [7:0] RST_FEN = 8'h00;
   localparam logic [31:0] RST_FLAGS = 32'h0000_0000;
   localparam logic [1:0] RST_IRQ = 2'h0;

endpackage

/* File: core/rx_flag_bank.sv */
// Bank of sticky flags that hardware sets and software clears
`timescale 1ns/1ns
module rx_flag_bank #(
   parameter int N = 32
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Set and clear vectors
   input  wire logic [N-1:0] set_vec,
   input  wire logic [N-1:0] clr_vec,
   // Flags
   output logic [N-1:0]      flags_q
);
   import can_rx_pkg::*;

   logic [N-1:0] flags_d;

   // Set beats clear so an arrival during a clear is kept
   assign flags_d = (flags_q & ~clr_vec) | set_vec;

   // ==================================================================
   // Flag storage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flags_q <= '0;
      end else begin
         flags_q <= flags_d;
      end
   end

   a_set_wins: assert property (@(posedge clk) disable iff (rst)
      set_vec != '0 |=> (flags_q & $past(set_vec)) == $past(set_vec))
      else $error("flag set lost against clear");
endmodule // rx_flag_bank

/* File: test/can_node_model.sv */
// Far-side model: remote frames arriving and the buffer writer storing them
`timescale 1ns/1ns
module can_node_model (
   // Clock
   input  wire logic   clk,
   // Identifier strobe
   output logic        msg_valid,
   output logic        msg_ide,
   output logic [10:0] msg_sid,
   output logic [17:0] msg_eid,
   // Store strobe
   output logic        store_valid,
   output logic [4:0]  store_buf
);
   // ==========================================================
   // Quiet lines at time zero
   initial begin
      msg_valid = 1'b0;
      msg_ide = 1'b0;
      msg_sid = 11'h000;
      msg_eid = 18'h00000;
      store_valid = 1'b0;
      store_buf = 5'h00;
   end
   // One frame's identifier; lines invert after, so off-strobe sampling shows
   task automatic frame(input logic ide, input logic [10:0] std_identifier, input logic [17:0] ext_identifier);
      @(posedge clk);
      msg_valid <= 1'b1;
      msg_ide <= ide;
      msg_sid <= std_identifier;
      msg_eid <= ext_identifier;
      @(posedge clk);
      msg_valid <= 1'b0;
      msg_ide <= ~ide;
      msg_sid <= ~std_identifier;
      msg_eid <= ~ext_identifier;
   endtask
   // Buffer writer stores one message
   task automatic store(input logic [4:0] b);
      @(posedge clk);
      store_valid <= 1'b1;
      store_buf <= b;
      @(posedge clk);
      store_valid <= 1'b0;
      store_buf <= ~b;
   endtask
endmodule // can_node_model

/* File: test/testbench.sv */
// Self-checking bench for the acceptance masks and buffer flags
`timescale 1ns/1ns
module testbench;
   import can_rx_pkg::*;
   logic        clk;
   logic        rst;
   logic        cyc;
   logic        stb;
   logic        we;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] dat_i;
   logic [31:0] dat_o;
   logic        ack;
   logic        msg_valid;
   logic        msg_ide;
   logic [10:0] msg_sid;
   logic [17:0] msg_eid;
   logic        hit_valid;
   logic [3:0]  hit_filter;
   logic        store_valid;
   logic [4:0]  store_buf;
   logic        irq;
   int          fail_count = 0;
   int          comparisons = 0;
   logic [31:0] rd;
   // ==========================================================
   // Design and far side
   can_rx_accept i_can_rx_accept (.CLOCK(clk), .RESET(rst), .CYC_I(cyc), .STB_I(stb),
      .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_i), .DAT_O(dat_o), .ACK_O(ack),
      .MSG_VALID(msg_valid), .MSG_IDE(msg_ide), .MSG_SID(msg_sid), .MSG_EID(msg_eid),
      .HIT_VALID(hit_valid), .HIT_FILTER(hit_filter), .STORE_VALID(store_valid),
      .STORE_BUF(store_buf), .IRQ(irq));
   can_node_model i_can_node_model (.clk(clk), .msg_valid(msg_valid), .msg_ide(msg_ide),
      .msg_sid(msg_sid), .msg_eid(msg_eid), .store_valid(store_valid),
      .store_buf(store_buf));
   // Free-running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ==========================================================
   // Verdict in one place
   task automatic end_sim();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Classic single Wishbone cycle; waits for ack under a bound
   task automatic wb(input logic w, input logic [5:0] idx, input logic [15:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      sel <= 4'h3;
      dat_i <= {16'h0000, wd};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20) begin
         fail_count++;
         end_sim();
      end
   endtask
   task automatic rchk(input logic [5:0] idx, input logic [15:0] exp, input string what);
      wb(1'b0, idx, 16'h0000);
      chk(what, rd, {16'h0000, exp});
   endtask
   // Present one identifier and judge the acceptance pulse
   task automatic hit(input logic ide, input logic [10:0] std_identifier, input logic [17:0] ext_identifier,
                      input logic h);
      i_can_node_model.frame(ide, std_identifier, ext_identifier);
      #1;
      chk("hit_valid", {31'h0, hit_valid}, {31'h0, h});
   endtask
   task automatic irq_is(input logic v);
      repeat (2) @(posedge clk);
      #1;
      chk("irq", {31'h0, irq}, {31'h0, v});
   endtask
   // ==========================================================
   // Reset values and an unmapped word
   task automatic t_reset();
      rchk(W_FMSEL, 16'h0000, "mask_select");
      for (int i = 0; i < 4; i++) rchk(W_FULL_LO + 6'(i), 16'h0000, "flags");
      rchk(6'h3f, 16'h0000, "unmapped");
   endtask
   // Mask codes on filter 15, then filter 8 at the low end
   task automatic t_filter();
      wb(1'b1, W_MSTD0, 16'hfff4);
      rchk(W_MSTD0, 16'hffe0, "mask0_std");
      wb(1'b1, W_MSTD0 + 6'h1, 16'h001c);
      rchk(W_MSTD0 + 6'h1, 16'h0008, "mask1_std");
      wb(1'b1, W_MSTD0 + 6'h2, 16'hffe3);
      wb(1'b1, W_MEXT0 + 6'h2, 16'hffff);
      wb(1'b1, W_FILT0 + 6'h0e, 16'h2469);
      wb(1'b1, W_FILT0 + 6'h0f, 16'h5a5a);
      rchk(W_FILT0 + 6'h0f, 16'h5a5a, "filt15_ext");
      rchk(6'h3f, 16'h0000, "unmapped");
      wb(1'b1, W_FEN, 16'h0080);
      hit(1'b0, 11'h123, 18'h00000, 1'b1);
      chk("hit_filter", {28'h0, hit_filter}, 32'hf);
      hit(1'b0, 11'h122, 18'h00000, 1'b0);
      hit(1'b1, 11'h123, 18'h3ffff, 1'b1);
      wb(1'b1, W_FMSEL, 16'h4000);
      hit(1'b1, 11'h7ff, 18'h00001, 1'b1);
      hit(1'b0, 11'h123, 18'h00000, 1'b0);
      wb(1'b1, W_FMSEL, 16'h8000);
      hit(1'b1, 11'h123, 18'h15a5a, 1'b1);
      hit(1'b1, 11'h123, 18'h15a5b, 1'b0);
      hit(1'b1, 11'h123, 18'h05a5a, 1'b0);
      hit(1'b0, 11'h123, 18'h00000, 1'b1);
      wb(1'b1, W_FMSEL, 16'hc000);
      hit(1'b1, 11'h123, 18'h15a5a, 1'b0);
      wb(1'b1, W_FMSEL, 16'h0001);
      wb(1'b1, W_FEN, 16'h0001);
      rchk(W_FMSEL, 16'h0001, "mask_select");
      hit(1'b0, 11'h555, 18'h00000, 1'b1);
      chk("hit_filter", {28'h0, hit_filter}, 32'h8);
      rchk(W_HIT, 16'h0018, "last_hit");
      hit(1'b1, 11'h555, 18'h00000, 1'b0);
   endtask
   // Full and overflow flags with the overflow interrupt
   task automatic t_store();
      wb(1'b1, W_IRQ_CLR, 16'h0003);
      wb(1'b1, W_IRQ_EN, 16'h0002);
      irq_is(1'b0);
      i_can_node_model.store(5'd3);
      i_can_node_model.store(5'd20);
      i_can_node_model.store(5'd20);
      rchk(W_FULL_LO, 16'h0008, "full_lo");
      rchk(W_FULL_HI, 16'h0010, "full_hi");
      rchk(W_OVF_LO, 16'h0000, "ovf_lo");
      rchk(W_OVF_HI, 16'h0010, "ovf_hi");
      rchk(W_IRQ_STAT, 16'h0002, "irq_stat");
      irq_is(1'b1);
      wb(1'b1, W_FULL_LO, 16'hffff);
      rchk(W_FULL_LO, 16'h0008, "full_lo");
      wb(1'b1, W_FULL_LO, 16'hfff7);
      rchk(W_FULL_LO, 16'h0000, "full_lo");
      wb(1'b1, W_OVF_HI, 16'hffef);
      rchk(W_OVF_HI, 16'h0000, "ovf_hi");
      wb(1'b1, W_IRQ_CLR, 16'h0002);
      irq_is(1'b0);
      i_can_node_model.store(5'd20);
      rchk(W_OVF_HI, 16'h0010, "ovf_hi");
      irq_is(1'b1);
      wb(1'b1, W_IRQ_EN, 16'h0000);
      irq_is(1'b0);
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      rst = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'h0;
      dat_i = 32'h0000_0000;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_filter();
      t_store();
      end_sim();
   end
endmodule // testbench
